// ### rtl/mrp_pkg.sv
package mrp_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int MRP_REGIONS = 8;
  localparam logic [7:0] MRP_REGION_COUNT = 8'h08;
  localparam logic [4:0] MRP_SIZE_MIN = 5'h04;   // 2^(4+1) = 32 bytes
  localparam logic [4:0] MRP_SIZE_MAX = 5'h1F;   // 2^32 = 4 GB
  localparam logic [4:0] MRP_SIZE_SUB_MIN = 5'h07; // 256 bytes

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] MRP_OFS_CTRL = 8'h00;
  localparam logic [7:0] MRP_OFS_COUNT = 8'h04;
  localparam logic [7:0] MRP_OFS_SELECT = 8'h08;
  localparam logic [7:0] MRP_OFS_BASE = 8'h0C;
  localparam logic [7:0] MRP_OFS_ATTR = 8'h10;
  localparam logic [7:0] MRP_OFS_STATUS = 8'h14;
  localparam logic [7:0] MRP_OFS_MASK = 8'h18;
  localparam logic [7:0] MRP_OFS_FADDR = 8'h1C;

  // Control fields
  localparam int MRP_CTRL_ENABLE = 0;
  localparam int MRP_CTRL_PRIV_DEF = 1;
  localparam int MRP_CTRL_FLT_PROT = 2;

  // Attribute fields
  localparam int MRP_ATTR_ENABLE = 0;
  localparam int MRP_ATTR_SIZE_LSB = 1;
  localparam int MRP_ATTR_SUB_LSB = 8;
  localparam int MRP_ATTR_AP_LSB = 24;
  localparam int MRP_ATTR_XN = 28;

  // Status fields
  localparam int MRP_ST_FAULT = 0;
  localparam int MRP_ST_NOREGION = 1;

  // Reset values
  localparam logic [2:0] MRP_CTRL_RESET = 3'h0;
  localparam logic [1:0] MRP_IRQ_RESET = 2'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Access levels: privileged/user pairs
  typedef enum logic [2:0] {
    MRP_AP_NONE = 3'h0,
    MRP_AP_PRW_UNONE = 3'h1,
    MRP_AP_PRW_URO = 3'h2,
    MRP_AP_PRW_URW = 3'h3,
    MRP_AP_PRO_UNONE = 3'h5,
    MRP_AP_PRO_URO = 3'h6
  } mrp_ap_t;

  typedef struct packed {
    logic enable;
    logic [4:0] size;
    logic [7:0] sub_dis;
    logic [2:0] ap;
    logic xn;
    logic [26:0] base;   // address bits 31:5
  } mrp_region_t;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic write;
    logic fetch;
    logic priv;
    logic handler_hf_nmi;
  } mrp_access_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } mrp_bus_out_t;

endpackage : mrp_pkg

// ### rtl/mrp_checker.sv
// How it works
// R01 - Eight regions with base, size, permissions
// R02 - Sizes power of two, 32 B to 4 GB
// R03 - Software aligns base to region size
// R04 - Execute-never bit refuses instruction fetches
// R05 - Separate privileged and user access levels
// R06 - Eight sub-regions, each with disable bit
// R07 - Permission violation raises management fault
// R08 - Region enable keeps stored configuration
// R09 - Attribute readback includes enable bit
// R10 - Privileged default map when option set
// R11 - No enabled region without option faults
// R12 - Handler bypass unless fault-handler option
// R13 - Global disable: default map, no faults
// R14 - Read-only total region count
// R15 - Software disables region before changing
// R16 - Software configures regions before enabling
// R17 - Sub-regions only for 256 B or larger
// R18 - Highest-numbered matching region wins
// R19 - Reset clears global and region enables
//
// Chosen here: register access over Wishbone and the register addresses.
`timescale 1ns/1ns
module mrp_checker
  import mrp_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic acc_valid,
  input wire logic [31:0] acc_addr,
  input wire logic acc_write,
  input wire logic acc_fetch,
  input wire logic acc_priv,
  input wire logic acc_handler_hf_nmi,
  output logic mem_fault,
  output logic irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] ctrl;
    logic [2:0] sel;
    mrp_region_t [MRP_REGIONS-1:0] rgn;
    logic [1:0] status;
    logic [1:0] mask;
    logic [31:0] faddr;
    logic fault;
    logic irq;
    mrp_bus_out_t bus;
  } mrp_state_t;

  mrp_state_t st;
  mrp_state_t next_st;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // Sub-region index: three address bits just below the region size
  function automatic logic [2:0] mrp_sub_index(input logic [31:0] a, input logic [4:0] sz);
    logic [34:0] sh;
    sh = {3'h0, a} >> (sz - 5'h02);
    return sh[2:0];
  endfunction : mrp_sub_index

  function automatic logic mrp_hit(input mrp_region_t r, input logic [31:0] a);
    logic [31:0] m;
    logic in_rgn;
    m = 32'hFFFFFFFF;
    in_rgn = 1'b0;
    if (r.size >= MRP_SIZE_MIN) begin  // R02
      if (r.size == MRP_SIZE_MAX) begin
        m = 32'h00000000;
      end else begin
        m = 32'hFFFFFFFF << (r.size + 5'h01);
      end
      in_rgn = ((a & m) == ({r.base, 5'h00} & m));
    end
    if (in_rgn && r.size >= MRP_SIZE_SUB_MIN) begin  // R17
      in_rgn = !r.sub_dis[mrp_sub_index(a, r.size)];  // R06
    end
    return r.enable && in_rgn;  // R08
  endfunction : mrp_hit

  function automatic logic mrp_allowed(input logic [2:0] ap, input logic priv,
                                       input logic wr);
    logic ok;
    ok = 1'b0;
    case (ap)
      MRP_AP_PRW_UNONE: ok = priv;
      MRP_AP_PRW_URO: ok = priv || !wr;
      MRP_AP_PRW_URW: ok = 1'b1;
      MRP_AP_PRO_UNONE: ok = priv && !wr;
      MRP_AP_PRO_URO: ok = !wr;
      default: ok = 1'b0;
    endcase
    return ok;  // R05
  endfunction : mrp_allowed

  function automatic logic [31:0] mrp_attr_word(input mrp_region_t r);
    logic [31:0] w;
    w = 32'h00000000;
    w[MRP_ATTR_ENABLE] = r.enable;  // R09
    w[MRP_ATTR_SIZE_LSB +: 5] = r.size;
    w[MRP_ATTR_SUB_LSB +: 8] = r.sub_dis;
    w[MRP_ATTR_AP_LSB +: 3] = r.ap;
    w[MRP_ATTR_XN] = r.xn;
    return w;
  endfunction : mrp_attr_word

  // ----------------------------------------------------------------
  // Region match, highest index wins
  // ----------------------------------------------------------------
  logic [MRP_REGIONS-1:0] hit_vec;

  genvar gi;
  generate
    for (gi = 0; gi < MRP_REGIONS; gi++) begin : g_match
      assign hit_vec[gi] = mrp_hit(st.rgn[gi], acc_addr);  // R01
    end
  endgenerate

  logic any_hit;
  mrp_region_t win;
  logic any_enabled;

  always_comb begin
    any_hit = 1'b0;
    win = '0;
    any_enabled = 1'b0;
    for (int i = 0; i < MRP_REGIONS; i++) begin
      any_enabled = any_enabled | st.rgn[i].enable;
      if (hit_vec[i]) begin
        any_hit = 1'b1;
        win = st.rgn[i];  // R18
      end
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic bus_req;
  logic wr_req;
  logic protect;
  logic violation;
  logic noregion_evt;
  logic [1:0] evt;
  logic [31:0] wmask;

  always_comb begin
    next_st = st;
    bus_req = wb_cyc_i && wb_stb_i && !st.bus.ack;
    wr_req = bus_req && wb_we_i;
    wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // Global enable off or handler bypass: default map, never a fault
    protect = st.ctrl[MRP_CTRL_ENABLE]  // R13
      && (!acc_handler_hf_nmi || st.ctrl[MRP_CTRL_FLT_PROT]);  // R12
    violation = 1'b0;
    noregion_evt = 1'b0;
    if (acc_valid && protect) begin
      if (any_hit) begin
        violation = !mrp_allowed(win.ap, acc_priv, acc_write)  // R07
          || (acc_fetch && win.xn);  // R04
      end else if (!(acc_priv && st.ctrl[MRP_CTRL_PRIV_DEF])) begin  // R10
        violation = 1'b1;
        noregion_evt = !any_enabled;  // R11
      end
    end
    next_st.fault = violation;
    if (violation) begin
      next_st.faddr = acc_addr;
    end
    evt = {noregion_evt, violation};

    // Bus slave, one wait state: ack the cycle after the request
    next_st.bus.ack = bus_req;
    next_st.bus.rdata = 32'h00000000;
    if (bus_req && !wb_we_i) begin
      if (wb_adr_i == MRP_OFS_CTRL) begin
        next_st.bus.rdata = {29'h0, st.ctrl};
      end else if (wb_adr_i == MRP_OFS_COUNT) begin
        next_st.bus.rdata = {24'h0, MRP_REGION_COUNT};  // R14
      end else if (wb_adr_i == MRP_OFS_SELECT) begin
        next_st.bus.rdata = {29'h0, st.sel};
      end else if (wb_adr_i == MRP_OFS_BASE) begin
        next_st.bus.rdata = {st.rgn[st.sel].base, 5'h00};
      end else if (wb_adr_i == MRP_OFS_ATTR) begin
        next_st.bus.rdata = mrp_attr_word(st.rgn[st.sel]);  // R09
      end else if (wb_adr_i == MRP_OFS_STATUS) begin
        next_st.bus.rdata = {30'h0, st.status};
      end else if (wb_adr_i == MRP_OFS_MASK) begin
        next_st.bus.rdata = {30'h0, st.mask};
      end else if (wb_adr_i == MRP_OFS_FADDR) begin
        next_st.bus.rdata = st.faddr;
      end
    end

    // Write-one-to-clear, an event in the same cycle wins
    next_st.status = st.status | evt;
    if (wr_req) begin
      if (wb_adr_i == MRP_OFS_CTRL && wb_sel_i[0]) begin
        next_st.ctrl = wb_dat_i[2:0];
      end else if (wb_adr_i == MRP_OFS_SELECT && wb_sel_i[0]) begin
        next_st.sel = wb_dat_i[2:0];
      end else if (wb_adr_i == MRP_OFS_BASE) begin
        // Base is taken as written; alignment is the writer's duty
        next_st.rgn[st.sel].base =
          (st.rgn[st.sel].base & ~wmask[31:5]) | (wb_dat_i[31:5] & wmask[31:5]);  // R03
      end else if (wb_adr_i == MRP_OFS_ATTR) begin
        if (wb_sel_i[0]) begin
          next_st.rgn[st.sel].enable = wb_dat_i[MRP_ATTR_ENABLE];  // R08
          next_st.rgn[st.sel].size[2:0] = wb_dat_i[3:1];
        end
        if (wb_sel_i[0] && wb_sel_i[1]) begin
          next_st.rgn[st.sel].size = wb_dat_i[MRP_ATTR_SIZE_LSB +: 5];  // R02
        end
        if (wb_sel_i[1]) begin
          next_st.rgn[st.sel].sub_dis = wb_dat_i[MRP_ATTR_SUB_LSB +: 8];  // R06
        end
        if (wb_sel_i[3]) begin
          next_st.rgn[st.sel].ap = wb_dat_i[MRP_ATTR_AP_LSB +: 3];  // R05
          next_st.rgn[st.sel].xn = wb_dat_i[MRP_ATTR_XN];  // R04
        end
      end else if (wb_adr_i == MRP_OFS_STATUS && wb_sel_i[0]) begin
        next_st.status = (st.status & ~wb_dat_i[1:0]) | evt;
      end else if (wb_adr_i == MRP_OFS_MASK && wb_sel_i[0]) begin
        next_st.mask = wb_dat_i[1:0];
      end
    end
    next_st.irq = |(next_st.status & next_st.mask);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st <= '0;
      st.ctrl <= MRP_CTRL_RESET;  // R19
      st.status <= MRP_IRQ_RESET;
      st.mask <= MRP_IRQ_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign wb_ack_o = st.bus.ack;
  assign wb_dat_o = st.bus.rdata;
  assign mem_fault = st.fault;
  assign irq = st.irq;

endmodule : mrp_checker

// ### verification/mrp_prot_checker.sv
`timescale 1ns/1ns
module mrp_prot_checker
  import mrp_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic acc_valid,
  input wire logic [31:0] acc_addr,
  input wire logic acc_write,
  input wire logic acc_fetch,
  input wire logic acc_priv,
  input wire logic acc_handler_hf_nmi,
  input wire logic mem_fault,
  input wire logic irq
);
  // ----------------------------------------------------------------
  // Shadow of option bits, updated at the accepting edge
  // ----------------------------------------------------------------
  logic en;
  logic fp;
  logic mk;
  logic wr_ok;
  // The slave takes a write at the edge where the request stands and ack is still low
  assign wr_ok = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      en <= 1'b0;
      fp <= 1'b0;
      mk <= 1'b0;
    end else if (wr_ok && wb_adr_i == MRP_OFS_CTRL) begin
      en <= wb_dat_i[MRP_CTRL_ENABLE];
      fp <= wb_dat_i[MRP_CTRL_FLT_PROT];
    end else if (wr_ok && wb_adr_i == MRP_OFS_MASK) begin
      mk <= wb_dat_i[MRP_ST_FAULT];
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data without ack");
  a_count_read: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o &&
    wb_adr_i == MRP_OFS_COUNT |=> wb_dat_o == {24'h0, MRP_REGION_COUNT})
    else $error("region count wrong");
  a_fault_cause: assert property (mem_fault |-> $past(acc_valid))
    else $error("fault without access");
  a_off_quiet: assert property (acc_valid && !en |=> !mem_fault)
    else $error("fault while protection off");
  a_handler_bypass: assert property (acc_valid && acc_handler_hf_nmi && !fp |=> !mem_fault)
    else $error("fault in handler without option");
  a_irq_fault: assert property (mem_fault && mk |-> irq)
    else $error("unmasked fault without irq");
endmodule : mrp_prot_checker

bind mrp_checker mrp_prot_checker u_mrp_prot_checker (.*);

// ### verification/mrp_core_model.sv
`timescale 1ns/1ns
module mrp_core_model (
  input wire logic clock,
  output logic acc_valid,
  output logic [31:0] acc_addr,
  output logic acc_write,
  output logic acc_fetch,
  output logic acc_priv,
  output logic acc_handler_hf_nmi
);
  initial begin
    acc_valid = 1'b0;
    acc_addr = 32'h0;
    {acc_write, acc_fetch, acc_priv, acc_handler_hf_nmi} = 4'h0;
  end
  // One access per call; qualifiers are inverted afterwards so stale values never pass
  task access(input logic [31:0] a, input logic [3:0] m);
    @(posedge clock);
    acc_valid <= 1'b1;
    acc_addr <= a;
    {acc_write, acc_fetch, acc_priv, acc_handler_hf_nmi} <= m;
    @(posedge clock);
    acc_valid <= 1'b0;
    acc_addr <= ~a;
    {acc_write, acc_fetch, acc_priv, acc_handler_hf_nmi} <= ~m;
  endtask : access
endmodule : mrp_core_model

// ### verification/memory_region_protection_test.sv
`timescale 1ns/1ns
module memory_region_protection_test
  import mrp_pkg::*;
;
  logic clock, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, acc_addr;
  logic acc_valid, acc_write, acc_fetch, acc_priv, acc_handler_hf_nmi, mem_fault, irq;
  int num_errors, n_tests;
  mrp_checker u_mrp_checker (.*);
  mrp_core_model u_mrp_core_model (.clock, .acc_valid, .acc_addr, .acc_write, .acc_fetch,
    .acc_priv, .acc_handler_hf_nmi);
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task print_verdict;
    if (num_errors == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      $display("MISMATCH %0t %h %h", $time, g, e);
      num_errors++;
    end
  endtask : chk
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int i;
    @(posedge clock);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
    i = 0;
    // Ack and read data are taken as they stand at the rising edge
    do begin
      @(posedge clock);
      i++;
    end while (wb_ack_o !== 1'b1 && i < 50);
    if (i >= 50) begin
      num_errors++;
      print_verdict;
    end
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask : bus
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : rd
  // Mode bits: write, fetch, privileged, handler
  task ac(input logic [31:0] a, input logic [3:0] m, input logic e);
    u_mrp_core_model.access(a, m);
    #1;
    chk({31'h0, mem_fault}, {31'h0, e});
  endtask : ac
  initial begin
    {num_errors, n_tests} = 0;
    {rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = 0;
    wb_sel_i = 4'hF;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    rd(MRP_OFS_CTRL, 32'h0);
    rd(MRP_OFS_COUNT, 32'h8);
    rd(8'h20, 32'h0);
    ac(32'h1000, 4'h0, 1'b0);
    wr(MRP_OFS_MASK, 32'h1);
    wr(MRP_OFS_CTRL, 32'h1);
    ac(32'h1000, 4'h0, 1'b1);
    chk({31'h0, irq}, 32'h1);
    rd(MRP_OFS_STATUS, 32'h3);
    rd(MRP_OFS_FADDR, 32'h1000);
    wr(MRP_OFS_STATUS, 32'h3);
    rd(MRP_OFS_STATUS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(MRP_OFS_CTRL, 32'h3);
    ac(32'h1000, 4'h2, 1'b0);
    ac(32'h1000, 4'h0, 1'b1);
    wr(MRP_OFS_CTRL, 32'h1);
    ac(32'h1000, 4'h3, 1'b0);
    wr(MRP_OFS_CTRL, 32'h5);
    ac(32'h1000, 4'h3, 1'b1);
    wr(MRP_OFS_CTRL, 32'h0);
    wr(MRP_OFS_STATUS, 32'h3);
    wr(MRP_OFS_SELECT, 32'h0);
    wr(MRP_OFS_BASE, 32'h1000);
    wr(MRP_OFS_ATTR, 32'h1300020F);
    wr(MRP_OFS_CTRL, 32'h1);
    ac(32'h1004, 4'h8, 1'b0);
    ac(32'h1004, 4'h4, 1'b1);
    ac(32'h1020, 4'h0, 1'b1);
    ac(32'h1100, 4'h0, 1'b1);
    rd(MRP_OFS_STATUS, 32'h1);
    // No access runs while a region is rewritten
    wr(MRP_OFS_ATTR, 32'h0300FF0D);
    ac(32'h1020, 4'h0, 1'b0);
    wr(MRP_OFS_ATTR, 32'h0100000D);
    ac(32'h1040, 4'h2, 1'b0);
    ac(32'h1040, 4'h0, 1'b1);
    wr(MRP_OFS_ATTR, 32'h0200000D);
    ac(32'h1040, 4'h8, 1'b1);
    ac(32'h1040, 4'h0, 1'b0);
    ac(32'h1040, 4'hA, 1'b0);
    wr(MRP_OFS_ATTR, 32'h0500000D);
    ac(32'h1040, 4'h2, 1'b0);
    ac(32'h1040, 4'hA, 1'b1);
    ac(32'h1040, 4'h0, 1'b1);
    wr(MRP_OFS_ATTR, 32'h0700000D);
    ac(32'h1040, 4'h2, 1'b1);
    wr(MRP_OFS_ATTR, 32'h0000000D);
    ac(32'h1040, 4'h2, 1'b1);
    wr(MRP_OFS_ATTR, 32'h0600000D);
    ac(32'h1040, 4'h8, 1'b1);
    ac(32'h1040, 4'hA, 1'b1);
    ac(32'h1040, 4'h4, 1'b0);
    wr(MRP_OFS_SELECT, 32'h1);
    wr(MRP_OFS_BASE, 32'h1000);
    wr(MRP_OFS_ATTR, 32'h9);
    ac(32'h1000, 4'h0, 1'b1);
    ac(32'h1040, 4'h0, 1'b0);
    rd(MRP_OFS_ATTR, 32'h9);
    wr(MRP_OFS_ATTR, 32'h8);
    ac(32'h1000, 4'h0, 1'b0);
    rd(MRP_OFS_BASE, 32'h1000);
    wr(MRP_OFS_ATTR, 32'h9);
    ac(32'h1000, 4'h0, 1'b1);
    wr(MRP_OFS_CTRL, 32'h0);
    ac(32'h1000, 4'h0, 1'b0);
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    rd(MRP_OFS_CTRL, 32'h0);
    rd(MRP_OFS_ATTR, 32'h0);
    print_verdict;
  end
endmodule : memory_region_protection_test
